//--- pkg/ulfc_map.vh
/*
 line format block: register offsets, field positions, reset values and timing counts.
 assumes inclusion by bare name from the design files.
*/
`ifndef ULFC_MAP_VH
`define ULFC_MAP_VH
`define ULFC_OFF_LFR 8'h00
`define ULFC_OFF_DIVISOR 8'h04
`define ULFC_OFF_TXDATA 8'h08
`define ULFC_OFF_RXDATA 8'h0c
`define ULFC_OFF_STATUS 8'h10
`define ULFC_LFR_RESET 8'h00
`define ULFC_DIV_RESET 16'h0001
`define ULFC_BIT_DLAB 7
`define ULFC_BIT_BREAK 6
`define ULFC_BIT_STICK 5
`define ULFC_BIT_EVEN 4
`define ULFC_BIT_PEN 3
`define ULFC_BIT_STOP 2
`define ULFC_WLEN_MSB 1
`define ULFC_WLEN_LSB 0
`define ULFC_OVERSAMPLE 16
`define ULFC_RESP_OKAY 2'b00
`define ULFC_RESP_SLVERR 2'b10
`endif

//--- core/ulfc_tick.v
/*
 one-cycle enable pulse every div_value cycles (minimum one).
 assumes a single clock and synchronous active-high reset.
*/
`default_nettype none
module ulfc_tick #(
   parameter WIDTH = 16
) (
   input wire clk_sys,
   input wire srst,
   input wire [WIDTH-1:0] div_value,
   output reg tick_q
);
   reg [WIDTH-1:0] cnt_q;
   always @(posedge clk_sys)
   begin
      if (srst)
      begin
         cnt_q <= {WIDTH{1'b0}};
         tick_q <= 1'b0;
      end
      else if (cnt_q + {{(WIDTH-1){1'b0}}, 1'b1} >= div_value)
      begin
         cnt_q <= {WIDTH{1'b0}};
         tick_q <= 1'b1;
      end
      else
      begin
         cnt_q <= cnt_q + {{(WIDTH-1){1'b0}}, 1'b1};
         tick_q <= 1'b0;
      end
   end
endmodule // ulfc_tick
`default_nettype wire

//--- core/ulfc_top.v
/*
 line format control of one uart channel with a simple serial transmitter and receiver
 that follow the programmed character format; axi4-lite register slave.
 assumes synchronous inputs, one 100 MHz clock, synchronous active-high reset.
*/
// Our own choices: the AXI4-Lite slave port and the address map.
// Contract
// - divisor access bit 7 set opens the divisor latch, cleared (reset) closes it.
// - break bit 6 set holds the serial output low until software clears it.
// - break bit 6 clear, the reset value, lets the transmitter run normally.
// - parity on, forced on, select clear sends parity 1 and checks against 1.
// - parity on, forced on, select set sends parity 0 and checks against 0.
// - forced bit clear, the reset value, computes parity from the data.
// - unforced parity with select set gives even ones, select clear gives odd ones.
// - parity enable bit 3 adds and checks a parity bit; clear, the reset value, omits it.
// - stop length follows bit 2 together with the word length; bit 2 resets to 0.
// - the two-bit word length field sets data bits for transmit and receive.
`include "ulfc_map.vh"
`default_nettype none
module ulfc_top #(
   parameter DIV_WIDTH = 16
) (
   input wire clk_sys,
   input wire srst,
   input wire [7:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output reg s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output reg s_axi_wready,
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   input wire [7:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output reg s_axi_arready,
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   input wire rx_in,
   output reg tx_out_q
);
   // ***************************************************************
   // registers
   // ***************************************************************
   reg [7:0] lfr_q;
   reg [DIV_WIDTH-1:0] div_q;
   reg [7:0] tx_hold_q;
   reg tx_full_q;
   reg [7:0] rx_data_q;
   reg rx_full_q;
   reg rx_perr_q;
   reg rx_ferr_q;
   reg [7:0] awaddr_q;
   reg aw_have_q;
   reg [31:0] wdata_q;
   reg [3:0] wstrb_q;
   reg w_have_q;
   wire tick;
   wire [3:0] nbits;
   wire do_write;
   wire do_read;
   wire tx_take;
   wire rx_done;
   wire [7:0] rx_shift_w;
   wire rx_par_ok;
   wire rx_stop_ok;

   assign nbits = 4'h5 + {2'b00, lfr_q[`ULFC_WLEN_MSB:`ULFC_WLEN_LSB]};
   assign do_write = aw_have_q && w_have_q && !s_axi_bvalid;

   // ***************************************************************
   // axi4-lite write channel
   // ***************************************************************
   always @(posedge clk_sys)
   begin
      if (srst)
      begin
         s_axi_awready <= 1'b1;
         s_axi_wready <= 1'b1;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `ULFC_RESP_OKAY;
         aw_have_q <= 1'b0;
         w_have_q <= 1'b0;
         awaddr_q <= 8'h00;
         wdata_q <= 32'h00000000;
         wstrb_q <= 4'h0;
         lfr_q <= `ULFC_LFR_RESET;
         div_q <= `ULFC_DIV_RESET;
         tx_hold_q <= 8'h00;
         tx_full_q <= 1'b0;
      end
      else
      begin
         if (s_axi_awvalid && s_axi_awready)
         begin
            awaddr_q <= s_axi_awaddr;
            aw_have_q <= 1'b1;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            wdata_q <= s_axi_wdata;
            wstrb_q <= s_axi_wstrb;
            w_have_q <= 1'b1;
            s_axi_wready <= 1'b0;
         end
         if (tx_take)
            tx_full_q <= 1'b0;
         if (do_write)
         begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= `ULFC_RESP_OKAY;
            case ({awaddr_q[7:2], 2'b00})
               `ULFC_OFF_LFR:
                  if (wstrb_q[0])
                     lfr_q <= wdata_q[7:0];
               `ULFC_OFF_DIVISOR:
                  if (lfr_q[`ULFC_BIT_DLAB])
                  begin
                     if (wstrb_q[0])
                        div_q[7:0] <= wdata_q[7:0];
                     if (wstrb_q[1])
                        div_q[DIV_WIDTH-1:8] <= wdata_q[DIV_WIDTH-1:8];
                  end
                  else
                     s_axi_bresp <= `ULFC_RESP_SLVERR;
               `ULFC_OFF_TXDATA:
                  if (wstrb_q[0])
                  begin
                     tx_hold_q <= wdata_q[7:0];
                     tx_full_q <= 1'b1;
                  end
               `ULFC_OFF_STATUS:
                  s_axi_bresp <= `ULFC_RESP_OKAY;
               default:
                  s_axi_bresp <= `ULFC_RESP_SLVERR;
            endcase
         end
         if (s_axi_bvalid && s_axi_bready)
         begin
            s_axi_bvalid <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
         end
      end
   end

   // ***************************************************************
   // axi4-lite read channel
   // ***************************************************************
   assign do_read = s_axi_arvalid && s_axi_arready;
   always @(posedge clk_sys)
   begin
      if (srst)
      begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= `ULFC_RESP_OKAY;
      end
      else if (do_read)
      begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= `ULFC_RESP_OKAY;
         s_axi_rdata <= 32'h00000000;
         case ({s_axi_araddr[7:2], 2'b00})
            `ULFC_OFF_LFR:
               s_axi_rdata <= {24'h000000, lfr_q};
            `ULFC_OFF_DIVISOR:
               if (lfr_q[`ULFC_BIT_DLAB])
                  s_axi_rdata <= {{(32-DIV_WIDTH){1'b0}}, div_q};
               else
                  s_axi_rresp <= `ULFC_RESP_SLVERR;
            `ULFC_OFF_RXDATA:
               s_axi_rdata <= {24'h000000, rx_data_q};
            `ULFC_OFF_STATUS:
               s_axi_rdata <= {27'h0000000, rx_ferr_q, rx_perr_q, tx_full_q, rx_full_q};
            default:
               s_axi_rresp <= `ULFC_RESP_SLVERR;
         endcase
      end
      else if (s_axi_rvalid && s_axi_rready)
      begin
         s_axi_rvalid <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end

   // ***************************************************************
   // oversample tick every divisor cycles; a bit is divisor times oversample
   // ***************************************************************
   ulfc_tick #(
      .WIDTH(DIV_WIDTH)
   ) u_tick (
      .clk_sys(clk_sys),
      .srst(srst),
      .div_value(div_q),
      .tick_q(tick)
   );

   // ***************************************************************
   // transmitter
   // ***************************************************************
   localparam TX_IDLE = 5'b00001;
   localparam TX_START = 5'b00010;
   localparam TX_DATA = 5'b00100;
   localparam TX_PAR = 5'b01000;
   localparam TX_STOP = 5'b10000;
   reg [4:0] tx_st_q;
   reg [7:0] tx_sh_q;
   reg [3:0] tx_bit_q;
   reg [5:0] tx_os_q;
   reg tx_line_q;
   reg tx_par_q;
   wire tx_os_end;
   wire [5:0] stop_len;

   // stop length in oversample ticks: 16, 24 or 32
   assign stop_len = !lfr_q[`ULFC_BIT_STOP] ? 6'd16 :
                     (lfr_q[1:0] == 2'b00) ? 6'd24 : 6'd32;
   assign tx_os_end = (tx_st_q == TX_STOP) ? (tx_os_q == stop_len - 6'd1) : (tx_os_q == 6'd15);
   assign tx_take = tick && (tx_st_q == TX_IDLE) && tx_full_q;

   always @(posedge clk_sys)
   begin
      if (srst)
      begin
         tx_st_q <= TX_IDLE;
         tx_sh_q <= 8'h00;
         tx_bit_q <= 4'h0;
         tx_os_q <= 6'd0;
         tx_line_q <= 1'b1;
         tx_par_q <= 1'b0;
      end
      else if (tick)
      begin
         tx_os_q <= tx_os_end ? 6'd0 : tx_os_q + 6'd1;
         case (tx_st_q)
            TX_IDLE:
               if (tx_full_q)
               begin
                  tx_st_q <= TX_START;
                  tx_sh_q <= tx_hold_q;
                  tx_os_q <= 6'd0;
                  tx_line_q <= 1'b0;
                  // even select yields even total, else odd fixed when forced
                  tx_par_q <= lfr_q[`ULFC_BIT_STICK] ? !lfr_q[`ULFC_BIT_EVEN] :
                     (^(tx_hold_q & (8'hff >> (4'd8 - nbits))) ^ !lfr_q[`ULFC_BIT_EVEN]);
               end
            TX_START:
               if (tx_os_end)
               begin
                  tx_st_q <= TX_DATA;
                  tx_bit_q <= 4'h0;
                  tx_line_q <= tx_sh_q[0];
               end
            TX_DATA:
               if (tx_os_end)
               begin
                  tx_sh_q <= {1'b0, tx_sh_q[7:1]};
                  tx_bit_q <= tx_bit_q + 4'h1;
                  if (tx_bit_q == nbits - 4'h1)
                  begin
                     tx_st_q <= lfr_q[`ULFC_BIT_PEN] ? TX_PAR : TX_STOP;
                     tx_line_q <= lfr_q[`ULFC_BIT_PEN] ? tx_par_q : 1'b1;
                  end
                  else
                     tx_line_q <= tx_sh_q[1];
               end
            TX_PAR:
               if (tx_os_end)
               begin
                  tx_st_q <= TX_STOP;
                  tx_line_q <= 1'b1;
               end
            TX_STOP:
               if (tx_os_end)
                  tx_st_q <= TX_IDLE;
            default:
               tx_st_q <= TX_IDLE;
         endcase
      end
   end

   always @(posedge clk_sys)
   begin
      if (srst)
         tx_out_q <= 1'b1;
      else
         tx_out_q <= tx_line_q & !lfr_q[`ULFC_BIT_BREAK];
   end

   // ***************************************************************
   // receiver: samples mid-bit, checks parity and first stop bit
   // ***************************************************************
   localparam RX_IDLE = 4'b0001;
   localparam RX_START = 4'b0010;
   localparam RX_DATA = 4'b0100;
   localparam RX_TAIL = 4'b1000;
   reg [3:0] rx_st_q;
   reg [7:0] rx_sh_q;
   reg [3:0] rx_bit_q;
   reg [3:0] rx_os_q;
   reg rx_got_par_q;
   reg rx_par_phase_q;
   reg rx_done_q;

   assign rx_shift_w = rx_sh_q >> (4'd8 - nbits);
   assign rx_par_ok = !lfr_q[`ULFC_BIT_PEN] ||
      (lfr_q[`ULFC_BIT_STICK] ? (rx_got_par_q == !lfr_q[`ULFC_BIT_EVEN]) :
       ((^rx_shift_w ^ rx_got_par_q) == !lfr_q[`ULFC_BIT_EVEN]));
   assign rx_stop_ok = rx_in;
   assign rx_done = rx_done_q;

   always @(posedge clk_sys)
   begin
      if (srst)
      begin
         rx_st_q <= RX_IDLE;
         rx_sh_q <= 8'h00;
         rx_bit_q <= 4'h0;
         rx_os_q <= 4'h0;
         rx_got_par_q <= 1'b0;
         rx_par_phase_q <= 1'b0;
         rx_done_q <= 1'b0;
         rx_data_q <= 8'h00;
         rx_full_q <= 1'b0;
         rx_perr_q <= 1'b0;
         rx_ferr_q <= 1'b0;
      end
      else
      begin
         rx_done_q <= 1'b0;
         if (do_read && ({s_axi_araddr[7:2], 2'b00} == `ULFC_OFF_RXDATA))
            rx_full_q <= 1'b0;
         if (tick)
         begin
            rx_os_q <= rx_os_q + 4'h1;
            case (rx_st_q)
               RX_IDLE:
                  if (!rx_in)
                  begin
                     rx_st_q <= RX_START;
                     rx_os_q <= 4'h0;
                  end
               RX_START:
                  if (rx_os_q == 4'h7)
                  begin
                     rx_st_q <= rx_in ? RX_IDLE : RX_DATA;
                     rx_os_q <= 4'h0;
                     rx_bit_q <= 4'h0;
                  end
               RX_DATA:
                  if (rx_os_q == 4'hf)
                  begin
                     rx_sh_q <= {rx_in, rx_sh_q[7:1]};
                     rx_bit_q <= rx_bit_q + 4'h1;
                     if (rx_bit_q == nbits - 4'h1)
                     begin
                        rx_st_q <= RX_TAIL;
                        rx_par_phase_q <= lfr_q[`ULFC_BIT_PEN];
                     end
                  end
               RX_TAIL:
                  if (rx_os_q == 4'hf)
                  begin
                     if (rx_par_phase_q)
                     begin
                        rx_got_par_q <= rx_in;
                        rx_par_phase_q <= 1'b0;
                     end
                     else
                     begin
                        rx_st_q <= RX_IDLE;
                        rx_done_q <= 1'b1;
                        rx_data_q <= rx_shift_w;
                        rx_full_q <= 1'b1;
                        rx_perr_q <= !rx_par_ok;
                        rx_ferr_q <= !rx_stop_ok;
                     end
                  end
               default:
                  rx_st_q <= RX_IDLE;
            endcase
         end
      end
   end
endmodule // ulfc_top
`default_nettype wire

//--- test/ulfc_top_sva.sv
/* checker on the ulfc_top ports.
 assumes one clock, sync reset, a master that offers aw and w together. */
`include "ulfc_map.vh"
`default_nettype none
module ulfc_top_sva (
   input wire logic clk_sys,
   input wire logic srst,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic tx_out_q
);
   timeunit 1ns;
   timeprecision 1ns;
   // ************
   // assertions
   // ************
   default clocking @(posedge clk_sys); endclocking
   default disable iff (srst);
   logic wr_take, rd_take, brk_q, dlab_q;
   assign wr_take = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   assign rd_take = s_axi_arvalid && s_axi_arready;
   // shadow of break and divisor access bits
   always @(posedge clk_sys)
   begin
      if (srst)
      begin
         brk_q <= 1'b0;
         dlab_q <= 1'b0;
      end
      else if (wr_take && s_axi_awaddr == `ULFC_OFF_LFR)
      begin
         brk_q <= s_axi_wdata[6];
         dlab_q <= s_axi_wdata[7];
      end
   end
   break_low_a: assert property (brk_q && $past(brk_q) && $past(brk_q, 2) |-> !tx_out_q)
      else $error("serial output not low during break");
   reset_idle_a: assert property (disable iff (1'b0) srst |=> tx_out_q && s_axi_awready
      && s_axi_arready && !s_axi_bvalid && !s_axi_rvalid)
      else $error("outputs not idle after reset");
   bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
      && $stable(s_axi_bresp))
      else $error("write response dropped");
   rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
      && $stable(s_axi_rdata))
      else $error("read data dropped");
   read_answer_a: assert property (rd_take |=> s_axi_rvalid && !s_axi_arready)
      else $error("read not answered");
   write_answer_a: assert property (wr_take |-> ##[1:2] s_axi_bvalid)
      else $error("write not answered");
   div_lock_a: assert property (wr_take && s_axi_awaddr == `ULFC_OFF_DIVISOR && !dlab_q
      |-> ##[1:2] s_axi_bvalid && s_axi_bresp == `ULFC_RESP_SLVERR)
      else $error("locked divisor write accepted");
   unmapped_a: assert property (rd_take && s_axi_araddr[7:2] > (`ULFC_OFF_STATUS >> 2)
      |=> s_axi_rresp == `ULFC_RESP_SLVERR)
      else $error("unmapped read not refused");
   upper_zero_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
      else $error("upper read bits not zero");
   cover property (brk_q && !tx_out_q);
   cover property (wr_take && dlab_q);
   cover property (rd_take && s_axi_araddr == `ULFC_OFF_RXDATA);
endmodule // ulfc_top_sva
`default_nettype wire

//--- test/ulfc_serial_peer.sv
/* remote serial partner: samples the transmit line, drives the receive line.
 assumes 16 clocks a bit (divisor 1); receive line idles high. */
`default_nettype none
module ulfc_serial_peer (
   input wire logic clk_sys,
   input wire logic tx_line,
   input wire logic [3:0] nbits,
   output var logic rx_line,
   output var logic [11:0] got,
   output var int frames,
   output var int gap
);
   timeunit 1ns;
   timeprecision 1ns;
   // ************
   // line model
   // ************
   int cyc = 0;
   int t0 = 0;
   initial
   begin
      rx_line = 1'b1;
      frames = 0;
      got = 12'h000;
   end
   always @(posedge clk_sys) cyc <= cyc + 1;
   // start edge, then each bit sampled in its middle
   always
   begin
      @(negedge tx_line);
      gap = cyc - t0;
      t0 = cyc;
      repeat (8) @(posedge clk_sys);
      for (int i = 0; i < nbits; i++)
      begin
         repeat (16) @(posedge clk_sys);
         got[i] = tx_line;
      end
      frames++;
   end
   task automatic send(input logic [11:0] b, input int n);
      rx_line <= 1'b0;
      repeat (16) @(posedge clk_sys);
      for (int i = 0; i < n; i++)
      begin
         rx_line <= b[i];
         repeat (16) @(posedge clk_sys);
      end
      rx_line <= 1'b1;
   endtask
endmodule // ulfc_serial_peer
`default_nettype wire

//--- test/ulfc_top_bench.sv
/* self-checking bench for ulfc_top with a serial partner.
 assumes divisor 1, so a bit is 16 clocks. */
`include "ulfc_map.vh"
`default_nettype none
module ulfc_top_bench;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk_sys, srst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
   logic s_axi_rready, rx_in, tx_out_q;
   logic [7:0] s_axi_awaddr, s_axi_araddr, f, d;
   logic [31:0] s_axi_wdata, s_axi_rdata, rd;
   logic [3:0] s_axi_wstrb, nbits;
   logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
   logic [11:0] got, ex, mk;
   logic [15:0] rows [7] = '{16'h03a5, 16'h0015, 16'h092b, 16'h1a55, 16'h2b0f, 16'h3bf0, 16'h07c3};
   int frames, gap, n, fr, wt, eg;
   int num_errors = 0;
   int checked = 0;
   ulfc_top u_ulfc_top (.*);
   ulfc_serial_peer u_ulfc_serial_peer (.clk_sys(clk_sys), .tx_line(tx_out_q), .nbits(nbits),
      .rx_line(rx_in), .got(got), .frames(frames), .gap(gap));
   initial
   begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end
   // ************
   // helpers
   // ************
   task check(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task finish_test;
      $display("checked=%0d num_errors=%0d", checked, num_errors);
      if (num_errors == 0 && checked > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task wr(input logic [7:0] a, input logic [31:0] v);
      s_axi_awaddr <= a;
      s_axi_wdata <= v;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do
      begin
         @(posedge clk_sys);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
      rsp = s_axi_bresp;
      s_axi_bready <= 1'b0;
      @(posedge clk_sys);
   endtask
   task rdr(input logic [7:0] a);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do
      begin
         @(posedge clk_sys);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      rd = s_axi_rdata;
      rsp = s_axi_rresp;
      s_axi_rready <= 1'b0;
      @(posedge clk_sys);
   endtask
   // bits after the start bit, data first, then parity and one stop bit
   function automatic logic [11:0] frame(input logic [7:0] g, input logic [7:0] v);
      logic [7:0] m;
      m = v & (8'hff >> (3 - g[1:0]));
      frame = {4'h0, m};
      n = 5 + g[1:0];
      if (g[3])
      begin
         frame[n] = g[5] ? ~g[4] : (g[4] ? ^m : ~^m);
         n++;
      end
      frame[n] = 1'b1;
      n++;
   endfunction
   initial
   begin
      #600000;
      num_errors++;
      finish_test();
   end
   // ************
   // main sequence
   // ************
   initial
   begin
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
      s_axi_awaddr = 8'h00;
      s_axi_araddr = 8'h00;
      s_axi_wdata = 32'h0;
      s_axi_wstrb = 4'hf;
      nbits = 4'ha;
      srst = 1'b1;
      repeat (3) @(posedge clk_sys);
      srst <= 1'b0;
      @(posedge clk_sys);
      check(tx_out_q, 1'b1);
      rdr(`ULFC_OFF_LFR);
      check(rd, {24'h0, `ULFC_LFR_RESET});
      $display("reset test done");
      for (int k = 0; k < 7; k++)
      begin
         {f, d} = rows[k];
         ex = frame(f, d);
         mk = 12'hfff >> (12 - n);
         nbits <= n[3:0];
         wr(`ULFC_OFF_LFR, {24'h0, f});
         rdr(`ULFC_OFF_LFR);
         check(rd, {24'h0, f});
         fr = frames;
         wr(`ULFC_OFF_TXDATA, {24'h0, d});
         for (wt = 0; frames == fr && wt < 400; wt++) @(posedge clk_sys);
         check(got & mk, ex);
         u_ulfc_serial_peer.send(ex, n);
         rdr(`ULFC_OFF_RXDATA);
         check(rd, {24'h0, d & (8'hff >> (3 - f[1:0]))});
         rdr(`ULFC_OFF_STATUS);
         check(rd[3:2], 2'b00);
         $display("row %0d done", k);
      end
      for (int k = 0; k < 2; k++)
      begin
         f = k ? 8'h3b : 8'h2b;
         wr(`ULFC_OFF_LFR, {24'h0, f});
         ex = frame(f, 8'h00);
         ex[n - 2] = ~ex[n - 2];
         u_ulfc_serial_peer.send(ex, n);
         rdr(`ULFC_OFF_STATUS);
         check(rd[2], 1'b1);
         rdr(`ULFC_OFF_RXDATA);
      end
      $display("forced parity error test done");
      wr(`ULFC_OFF_DIVISOR, 32'h1);
      check(rsp, `ULFC_RESP_SLVERR);
      wr(`ULFC_OFF_LFR, 32'h83);
      wr(`ULFC_OFF_DIVISOR, 32'h1);
      check(rsp, `ULFC_RESP_OKAY);
      rdr(`ULFC_OFF_DIVISOR);
      check(rd, 32'h1);
      rdr(8'h20);
      check(rsp, `ULFC_RESP_SLVERR);
      wr(8'h24, 32'h0);
      check(rsp, `ULFC_RESP_SLVERR);
      $display("divisor and map test done");
      wr(`ULFC_OFF_LFR, 32'h43);
      repeat (50) @(posedge clk_sys);
      check(tx_out_q, 1'b0);
      wr(`ULFC_OFF_LFR, 32'h03);
      repeat (3) @(posedge clk_sys);
      check(tx_out_q, 1'b1);
      // let the partner finish the frame that the break edge started
      repeat (200) @(posedge clk_sys);
      $display("break test done");
      nbits <= 4'h1;
      for (int k = 0; k < 4; k++)
      begin
         f = k[1] ? (k[0] ? 8'h0c : 8'h03) : (k[0] ? 8'h07 : 8'h04);
         ex = frame(f, 8'h00);
         eg = (n - 1) * 16 + 16 + (!f[2] ? 16 : (f[1:0] == 2'b00 ? 24 : 32));
         wr(`ULFC_OFF_LFR, {24'h0, f});
         fr = frames;
         wr(`ULFC_OFF_TXDATA, 32'h0);
         do rdr(`ULFC_OFF_STATUS); while (rd[1]);
         wr(`ULFC_OFF_TXDATA, 32'h0);
         for (wt = 0; frames < fr + 2 && wt < 900; wt++) @(posedge clk_sys);
         check(gap >= eg && gap <= eg + 3, 1'b1);
      end
      $display("stop length test done");
      finish_test();
   end
endmodule // ulfc_top_bench
bind ulfc_top ulfc_top_sva u_sva (.*);
`default_nettype wire
